//--- pca_cfg_pkg.sv
// Constants shared by the counter array configuration logic.
// Assumes an 8-bit special function register space with byte addresses.
package pca_cfg_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CONTROL    = 8'hD8;
  localparam logic [7:0] ADDR_MODE       = 8'hD9;
  localparam logic [7:0] ADDR_CMP_CLEAR  = 8'h9C;
  localparam logic [7:0] ADDR_PWM_CFG    = 8'hF7;
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'hF9;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_CMP_BASE   = 8'hFB;  // Channel n low byte at base+2n, high at base+2n+1

  // ==========================================================================
  // Field positions
  localparam int CTRL_OVF_BIT    = 7;
  localparam int CTRL_RUN_BIT    = 6;
  localparam int MODE_IDLE_BIT   = 7;
  localparam int MODE_TB_LSB     = 1;
  localparam int MODE_OVF_EN_BIT = 0;
  localparam int PWM_RELOAD_BIT  = 7;
  localparam int PWM_COV_EN_BIT  = 6;
  localparam int PWM_COV_BIT     = 5;
  localparam int PWM_CYCLE_LENGTH_SEL_LSB   = 0;
  localparam int CLR_POL_BIT     = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] PWM_RESET   = 8'h00;
  localparam logic [7:0] CLEAR_RESET = 8'h00;

  // ==========================================================================
  // Timebase codes and divider counts
  localparam logic [2:0] TB_SYS_DIV12 = 3'h0;
  localparam logic [2:0] TB_SYS_DIV4  = 3'h1;
  localparam logic [2:0] TB_TIMER0    = 3'h2;
  localparam logic [2:0] TB_EXT_FALL  = 3'h3;
  localparam logic [2:0] TB_SYS       = 3'h4;
  localparam logic [2:0] TB_EXT_DIV8  = 3'h5;
  localparam logic [2:0] TB_LFO_DIV8  = 3'h6;
  localparam logic [3:0] SYS_DIV_LONG = 4'hC;
  localparam logic [2:0] SLOW_DIV     = 3'h7;  // Terminal count of the divide-by-8

  // Cycle length codes
  localparam logic [2:0] CL_8BIT  = 3'h0;
  localparam logic [2:0] CL_9BIT  = 3'h1;
  localparam logic [2:0] CL_10BIT = 3'h2;
  localparam logic [2:0] CL_11BIT = 3'h3;

endpackage

//--- pca_timebase.sv
// Count pulse generator for the counter array.
// Assumes timer0_ovf_in is a pulse in the system clock domain; the other sources are synchronised here.
`timescale 1ns/1ps
module pca_timebase (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Control
  input  wire logic [2:0] timebase_select_in,
  input  wire logic       freeze_in,
  // Count sources
  input  wire logic       timer0_ovf_in,
  input  wire logic       ext_count_input_in,
  input  wire logic       ext_clk_in,
  input  wire logic       lfo_clk_in,
  // Count pulse
  output logic            tick_out
);

  logic [3:0] presc_reg;
  logic [2:0] ext_sync_reg;
  logic [2:0] eclk_sync_reg;
  logic [2:0] lfo_sync_reg;
  logic [2:0] eclk_div_reg;
  logic [2:0] lfo_div_reg;

  // ==========================================================================
  // Edge detection after two-flop synchronisers
  wire ext_fall  = ext_sync_reg[2] & ~ext_sync_reg[1];
  wire eclk_rise = eclk_sync_reg[1] & ~eclk_sync_reg[2];
  wire lfo_rise  = lfo_sync_reg[1] & ~lfo_sync_reg[2];
  wire presc_end = (presc_reg == pca_cfg_pkg::SYS_DIV_LONG - 4'h1);

  // Source pulses; dividers stop while frozen so that idle really suspends
  wire run       = ~freeze_in;
  wire tick12    = run & presc_end;
  wire tick4     = run & (presc_reg[1:0] == 2'h3);
  wire tick_eclk = run & eclk_rise & (eclk_div_reg == pca_cfg_pkg::SLOW_DIV);
  wire tick_lfo  = run & lfo_rise & (lfo_div_reg == pca_cfg_pkg::SLOW_DIV);

  // Source mux; the reserved code gives no pulse
  always_comb begin
    case (timebase_select_in)
      pca_cfg_pkg::TB_SYS_DIV12: tick_out = tick12;
      pca_cfg_pkg::TB_SYS_DIV4:  tick_out = tick4;
      pca_cfg_pkg::TB_TIMER0:    tick_out = run & timer0_ovf_in;
      pca_cfg_pkg::TB_EXT_FALL:  tick_out = run & ext_fall;
      pca_cfg_pkg::TB_SYS:       tick_out = run;
      pca_cfg_pkg::TB_EXT_DIV8:  tick_out = tick_eclk;
      pca_cfg_pkg::TB_LFO_DIV8:  tick_out = tick_lfo;
      default:                   tick_out = 1'b0;
    endcase
  end

  // Synchronisers, prescaler and slow-clock dividers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      presc_reg     <= 4'h0;
      ext_sync_reg  <= 3'h7;
      eclk_sync_reg <= 3'h0;
      lfo_sync_reg  <= 3'h0;
      eclk_div_reg  <= 3'h0;
      lfo_div_reg   <= 3'h0;
    end else begin
      ext_sync_reg  <= {ext_sync_reg[1:0], ext_count_input_in};
      eclk_sync_reg <= {eclk_sync_reg[1:0], ext_clk_in};
      lfo_sync_reg  <= {lfo_sync_reg[1:0], lfo_clk_in};
      if (run) begin
        presc_reg <= presc_end ? 4'h0 : presc_reg + 4'h1;
      end
      if (run && eclk_rise) begin
        eclk_div_reg <= eclk_div_reg + 3'h1;
      end
      if (run && lfo_rise) begin
        lfo_div_reg <= lfo_div_reg + 3'h1;
      end
    end
  end

endmodule // pca_timebase

//--- pca_timebase_pwm_config.sv
// Contract
// - Idle select freezes array during processor idle
// - Timebase field picks counter increment source
// - External clock/8 synchronised before counting
// - Counter overflow irq gated by enable
// - Reload select steers compare byte accesses
// - Reload used only in 9-11 bit PWM
// - Cycle overflow irq gated by enable
// - Cycle overflow set at selected counter bit
// - Cycle overflow cleared only by software
// - Cycle length codes 8 to 11 bits
// - Cycle length ignored by 16-bit channels
// - Clear register: polarity bit7, enables 2:0
// - Counter overflow flag set on wrap
// - Clear polarity selects falling or rising edge
// - Enabled channel forced low for the cycle
//
// Counter array timebase, PWM cycle configuration and comparator clear.
// Assumes a single-cycle special function register port driven by the core.
`timescale 1ns/1ps
module pca_timebase_pwm_config #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  // Register port
  input  wire logic [7:0]            sfr_addr_in,
  input  wire logic                  sfr_wr_in,
  input  wire logic                  sfr_rd_in,
  input  wire logic [7:0]            sfr_wdata_in,
  output logic      [7:0]            sfr_rdata_out,
  // System status and count sources
  input  wire logic                  cpu_idle_in,
  input  wire logic                  timer0_ovf_in,
  input  wire logic                  ext_count_input_in,
  input  wire logic                  ext_clk_in,
  input  wire logic                  lfo_clk_in,
  input  wire logic                  comparator_in,
  // Channel logic
  input  wire logic [CHANNELS-1:0]   channel_raw_in,
  input  wire logic [CHANNELS-1:0]   channel_pwm_in,
  input  wire logic [CHANNELS-1:0]   channel_pwm16_in,
  output logic      [CHANNELS-1:0]   channel_output_out,
  output logic      [CHANNELS*16-1:0] compare_value_out,
  output logic      [15:0]           main_counter_out,
  output logic      [2:0]            cycle_length_sel_out,
  // Interrupt request
  output logic                       irq_out
);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 3) begin
      $error("CHANNELS must be 1 to 3");
    end
  end

  // ==========================================================================
  // Register state
  logic [15:0] main_counter_reg;
  logic        counter_overflow_flag_reg;
  logic        counter_run_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  pwm_reg;
  logic [7:0]  clear_reg;
  logic [1:0]  cmp_sync_reg;
  logic        cmp_prev_reg;
  logic [15:0] cmp_store_reg [CHANNELS];
  logic [15:0] reload_reg    [CHANNELS];
  logic        tick;

  // Field decode
  wire       idle_suspend_sel   = mode_reg[pca_cfg_pkg::MODE_IDLE_BIT];
  wire [2:0] timebase_select    = mode_reg[pca_cfg_pkg::MODE_TB_LSB +: 3];
  wire       overflow_irq_en    = mode_reg[pca_cfg_pkg::MODE_OVF_EN_BIT];
  wire       reload_access_sel  = pwm_reg[pca_cfg_pkg::PWM_RELOAD_BIT];
  wire       cycle_ovf_irq_en   = pwm_reg[pca_cfg_pkg::PWM_COV_EN_BIT];
  wire       cycle_ovf_flag     = pwm_reg[pca_cfg_pkg::PWM_COV_BIT];
  wire [2:0] cycle_length_sel   = pwm_reg[pca_cfg_pkg::PWM_CYCLE_LENGTH_SEL_LSB +: 3];
  wire       cmp_clear_polarity = clear_reg[pca_cfg_pkg::CLR_POL_BIT];
  wire [2:0] cmp_clear_en       = clear_reg[2:0];

  // Register port decode
  wire wr_ctrl  = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_CONTROL);
  wire wr_mode  = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_MODE);
  wire wr_pwm   = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_PWM_CFG);
  wire wr_clr   = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_CMP_CLEAR);
  wire wr_cl    = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_COUNT_LOW);
  wire wr_ch    = sfr_wr_in & (sfr_addr_in == pca_cfg_pkg::ADDR_COUNT_HIGH);
  // Nine bits wide so that low addresses never alias onto a compare byte
  wire [8:0] cmp_off = {1'b0, sfr_addr_in} - {1'b0, pca_cfg_pkg::ADDR_CMP_BASE};

  // ==========================================================================
  // Timebase and counting
  wire freeze = idle_suspend_sel & cpu_idle_in;

  pca_timebase u_timebase (
    .clk_in             (clk_in),
    .sys_rst_in         (sys_rst_in),
    .timebase_select_in (timebase_select),
    .freeze_in          (freeze),
    .timer0_ovf_in      (timer0_ovf_in),
    .ext_count_input_in (ext_count_input_in),
    .ext_clk_in         (ext_clk_in),
    .lfo_clk_in         (lfo_clk_in),
    .tick_out           (tick)
  );

  // A counter byte write wins over the advance, so no flag fires for a skipped count
  wire count_en  = tick & counter_run_reg & ~freeze & ~wr_cl & ~wr_ch;
  wire wrap16    = count_en & (main_counter_reg == 16'hFFFF);
  // Cycle end: low N bits all ones as the counter advances; reserved codes never end
  wire cl_valid  = (cycle_length_sel <= pca_cfg_pkg::CL_11BIT);
  wire [10:0] cl_mask = {cycle_length_sel[1:0] == 2'h3, cycle_length_sel[1:0] >= 2'h2,
                         cycle_length_sel[1:0] >= 2'h1, 8'hFF};
  wire cycle_end = count_en & cl_valid & ((main_counter_reg[10:0] & cl_mask) == cl_mask);
  wire reload_mode = (cycle_length_sel >= pca_cfg_pkg::CL_9BIT) &&
                     (cycle_length_sel <= pca_cfg_pkg::CL_11BIT);

  // Counter, control bits and software-written configuration
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_counter_reg          <= 16'h0000;
      counter_overflow_flag_reg <= 1'b0;
      counter_run_reg           <= 1'b0;
      mode_reg                  <= pca_cfg_pkg::MODE_RESET;
      pwm_reg                   <= pca_cfg_pkg::PWM_RESET;
      clear_reg                 <= pca_cfg_pkg::CLEAR_RESET;
    end else begin
      if (wr_cl) begin
        main_counter_reg[7:0] <= sfr_wdata_in;
      end else if (wr_ch) begin
        main_counter_reg[15:8] <= sfr_wdata_in;
      end else if (count_en) begin
        main_counter_reg <= main_counter_reg + 16'h0001;
      end
      // Hardware set wins over a software clear in the same cycle
      if (wrap16) begin
        counter_overflow_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        counter_overflow_flag_reg <= sfr_wdata_in[pca_cfg_pkg::CTRL_OVF_BIT];
      end
      if (wr_ctrl) begin
        counter_run_reg <= sfr_wdata_in[pca_cfg_pkg::CTRL_RUN_BIT];
      end
      if (wr_mode) begin
        mode_reg <= sfr_wdata_in & 8'h8F;
      end
      if (wr_pwm) begin
        pwm_reg <= sfr_wdata_in & 8'hE7;
      end
      if (cycle_end) begin
        pwm_reg[pca_cfg_pkg::PWM_COV_BIT] <= 1'b1;
      end
      if (wr_clr) begin
        clear_reg <= sfr_wdata_in & 8'h87;
      end
    end
  end

  // ==========================================================================
  // Comparator synchroniser and active-edge detect
  wire cmp_level = cmp_sync_reg[1];
  wire cmp_at_active = cmp_clear_polarity ? cmp_level : ~cmp_level;
  wire cmp_edge = cmp_clear_polarity ? (cmp_level & ~cmp_prev_reg)
                                     : (~cmp_level & cmp_prev_reg);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmp_sync_reg <= 2'h0;
      cmp_prev_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_in};
      cmp_prev_reg <= cmp_sync_reg[1];
    end
  end

  // ==========================================================================
  // Per-channel compare storage, reload and comparator clear
  logic [7:0] ch_rdata [CHANNELS];
  logic [CHANNELS-1:0] ch_hit;
  logic [CHANNELS-1:0] clear_hold;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic        hold_reg;
      logic        out_reg;
      wire         sel_lo   = (cmp_off == 9'(2 * g));
      wire         sel_hi   = (cmp_off == 9'(2 * g + 1));
      // A 16-bit channel starts its cycle on the full wrap, others on the cycle end
      wire         ch_start = channel_pwm16_in[g] ? wrap16 : cycle_end;
      wire         ch_clr   = cmp_clear_en[g] & channel_pwm_in[g];
      wire [15:0]  shown    = reload_access_sel ? reload_reg[g] : cmp_store_reg[g];
      assign ch_hit[g]   = sel_lo | sel_hi;
      assign ch_rdata[g] = sel_hi ? shown[15:8] : shown[7:0];
      assign clear_hold[g] = hold_reg;
      assign channel_output_out[g] = out_reg;
      assign compare_value_out[16*g +: 16] = cmp_store_reg[g];

      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          cmp_store_reg[g] <= 16'h0000;
          reload_reg[g]    <= 16'h0000;
          hold_reg         <= 1'b0;
          out_reg          <= 1'b0;
        end else begin
          if (sfr_wr_in && sel_lo && reload_access_sel) begin
            reload_reg[g][7:0] <= sfr_wdata_in;
          end
          if (sfr_wr_in && sel_hi && reload_access_sel) begin
            reload_reg[g][15:8] <= sfr_wdata_in;
          end
          if (sfr_wr_in && sel_lo && !reload_access_sel) begin
            cmp_store_reg[g][7:0] <= sfr_wdata_in;
          end else if (sfr_wr_in && sel_hi && !reload_access_sel) begin
            cmp_store_reg[g][15:8] <= sfr_wdata_in;
          end else if (cycle_end && reload_mode && channel_pwm_in[g] && !channel_pwm16_in[g]) begin
            cmp_store_reg[g] <= reload_reg[g];
          end
          // Edge starts a clear; it persists across cycles while the level stays active
          if (!ch_clr) begin
            hold_reg <= 1'b0;
          end else if (cmp_edge) begin
            hold_reg <= 1'b1;
          end else if (ch_start) begin
            hold_reg <= cmp_at_active;
          end
          out_reg <= channel_raw_in[g] & ~(ch_clr & (hold_reg | cmp_edge));
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read mux; unmapped addresses read zero
  logic [7:0] ch_read;
  always_comb begin
    ch_read = 8'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      if (ch_hit[i]) begin
        ch_read = ch_rdata[i];
      end
    end
  end

  wire [7:0] ctrl_read = {counter_overflow_flag_reg, counter_run_reg, 6'h00};

  always_comb begin
    case (sfr_addr_in)
      pca_cfg_pkg::ADDR_CONTROL:    sfr_rdata_out = ctrl_read;
      pca_cfg_pkg::ADDR_MODE:       sfr_rdata_out = mode_reg;
      pca_cfg_pkg::ADDR_PWM_CFG:    sfr_rdata_out = pwm_reg;
      pca_cfg_pkg::ADDR_CMP_CLEAR:  sfr_rdata_out = clear_reg;
      pca_cfg_pkg::ADDR_COUNT_LOW:  sfr_rdata_out = main_counter_reg[7:0];
      pca_cfg_pkg::ADDR_COUNT_HIGH: sfr_rdata_out = main_counter_reg[15:8];
      default:                      sfr_rdata_out = sfr_rd_in ? ch_read : 8'h00;
    endcase
  end

  // Interrupt request and status outputs
  assign irq_out = (counter_overflow_flag_reg & overflow_irq_en) |
                   (cycle_ovf_flag & cycle_ovf_irq_en);
  assign main_counter_out     = main_counter_reg;
  assign cycle_length_sel_out = cycle_length_sel;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_idle_freeze;
    (idle_suspend_sel && cpu_idle_in && !wr_cl && !wr_ch) |=> $stable(main_counter_reg);
  endproperty
  a_idle_freeze: assert property (p_idle_freeze) else $error("counter moved in idle");

  property p_sys_tick;
    (timebase_select == pca_cfg_pkg::TB_SYS && counter_run_reg && !freeze && !wr_cl && !wr_ch)
      |=> main_counter_reg == $past(main_counter_reg) + 16'h0001;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system clock source missed");

  property p_reserved_tb;
    (timebase_select == 3'h7) |-> !count_en;
  endproperty
  a_reserved_tb: assert property (p_reserved_tb) else $error("reserved source counted");

  property p_irq_ovf;
    (counter_overflow_flag_reg && overflow_irq_en) |-> irq_out;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow irq missing");

  property p_irq_masked;
    (!overflow_irq_en && !(cycle_ovf_flag && cycle_ovf_irq_en)) |-> !irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");

  property p_wrap_sets_flag;
    wrap16 |=> counter_overflow_flag_reg && main_counter_reg == 16'h0000;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap flag not set");

  property p_cov_sticky;
    (cycle_ovf_flag && !wr_pwm) |=> cycle_ovf_flag;
  endproperty
  a_cov_sticky: assert property (p_cov_sticky) else $error("cycle flag dropped");

  property p_cov_8bit;
    (count_en && cycle_length_sel == pca_cfg_pkg::CL_8BIT && main_counter_reg[7:0] == 8'hFF)
      |=> cycle_ovf_flag;
  endproperty
  a_cov_8bit: assert property (p_cov_8bit) else $error("8-bit cycle end missed");

  property p_clr_reserved;
    clear_reg[6:3] == 4'h0;
  endproperty
  a_clr_reserved: assert property (p_clr_reserved) else $error("reserved clear bits set");

  property p_ch_forced_low;
    (cmp_edge && cmp_clear_en[0] && channel_pwm_in[0]) |=> !channel_output_out[0] && clear_hold[0];
  endproperty
  a_ch_forced_low: assert property (p_ch_forced_low) else $error("channel not cleared");

  c_wrap:      cover property (wrap16);
  c_cycle_end: cover property (cycle_end && cycle_length_sel == pca_cfg_pkg::CL_11BIT);
  c_clear:     cover property (cmp_edge && |cmp_clear_en);

endmodule // pca_timebase_pwm_config

//--- testbench.sv
// Self-checking bench for the counter array timebase and PWM configuration block.
// Assumes the design's default of three channels and a 100 MHz system clock.
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Stimulus and observed signals
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  sfr_addr_in = 8'h00;
  logic        sfr_wr_in = 1'b0;
  logic        sfr_rd_in = 1'b0;
  logic [7:0]  sfr_wdata_in = 8'h00;
  logic [7:0]  sfr_rdata_out;
  logic        cpu_idle_in = 1'b0;
  logic        timer0_ovf_in = 1'b0;
  logic        ext_count_input_in = 1'b1;
  logic        comparator_in = 1'b1;
  logic [2:0]  channel_raw_in = 3'h7;
  logic [2:0]  channel_pwm_in = 3'h7;
  logic [2:0]  channel_pwm16_in = 3'h0;
  logic [2:0]  cycle_length_sel_out;
  logic        slow_clk = 1'b0;
  logic [2:0]  channel_output_out;
  logic [47:0] compare_value_out;
  logic [15:0] main_counter_out;
  logic [15:0] snap_cnt;
  logic        irq_out;
  int          errors = 0;
  int          cmp_count = 0;

  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  // Write then read back; reserved bits and unmapped places must read zero
  row_t rows [7] = '{'{8'hD9, 8'hFF, 8'h8F}, '{8'hF7, 8'hFF, 8'hE7}, '{8'h9C, 8'hFF, 8'h87},
                     '{8'h01, 8'hFF, 8'h00}, '{8'hD9, 8'h00, 8'h00}, '{8'hF7, 8'h00, 8'h00},
                     '{8'h9C, 8'h00, 8'h00}};
  // Timebase codes run from the system clock, plus the reserved code, with the counts expected in 24 cycles
  logic [2:0]  codes [5] = '{3'h4, 3'h1, 3'h0, 3'h7, 3'h4};
  logic [15:0] dexp  [5] = '{16'd24, 16'd6, 16'd2, 16'd0, 16'd24};

  always #5 clk_in = ~clk_in;

  pca_timebase_pwm_config uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .cpu_idle_in(cpu_idle_in), .timer0_ovf_in(timer0_ovf_in), .ext_count_input_in(ext_count_input_in),
    .ext_clk_in(slow_clk), .lfo_clk_in(slow_clk), .comparator_in(comparator_in), .channel_raw_in(channel_raw_in),
    .channel_pwm_in(channel_pwm_in), .channel_pwm16_in(channel_pwm16_in), .channel_output_out(channel_output_out),
    .compare_value_out(compare_value_out), .main_counter_out(main_counter_out),
    .cycle_length_sel_out(cycle_length_sel_out), .irq_out(irq_out));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, taken at the second edge; returns once the write has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in    <= 1'b0;
    @(negedge clk_in);
  endtask

  // Read data is combinational, so it is sampled mid-cycle
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in   <= 1'b1;
    @(negedge clk_in);
    chk({8'h00, sfr_rdata_out}, {8'h00, exp});
    @(posedge clk_in);
    sfr_rd_in   <= 1'b0;
  endtask

  task automatic snap;
    @(negedge clk_in);
    snap_cnt = main_counter_out;
  endtask

  task automatic run_delta(input int cyc, input logic [15:0] exp);
    repeat (cyc) @(posedge clk_in);
    @(negedge clk_in);
    chk(main_counter_out - snap_cnt, exp);
  endtask

  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(8'hD9, 8'h00);
    rdc(8'hF7, 8'h00);
    rdc(8'h9C, 8'h00);
    chk({15'h0, irq_out}, 16'h0000);
    // Register table rows
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].exp);
    end
    // Timebase sources driven by the system clock, plus the reserved code
    wr(8'hD8, 8'h40);
    // Slow external and oscillator sources count every eighth rising edge
    for (int c = 5; c <= 6; c++) begin
      wr(8'hD9, {4'h0, 3'(c), 1'b0});
      snap();
      repeat (32) begin
        @(posedge clk_in) slow_clk <= ~slow_clk;
        @(posedge clk_in);
      end
      run_delta(4, 16'd2);
    end
    foreach (codes[i]) begin
      wr(8'hD9, {4'h0, codes[i], 1'b0});
      repeat (12) @(posedge clk_in);
      snap();
      run_delta(24, dexp[i]);
    end
    // Idle suspension only when selected
    @(posedge clk_in) cpu_idle_in <= 1'b1;
    snap();
    run_delta(24, 16'd24);
    wr(8'hD9, 8'h88);
    snap();
    run_delta(24, 16'd0);
    @(posedge clk_in) cpu_idle_in <= 1'b0;
    // Timer zero overflow pulses
    wr(8'hD9, 8'h04);
    snap();
    repeat (4) begin
      @(posedge clk_in) timer0_ovf_in <= 1'b1;
      @(posedge clk_in) timer0_ovf_in <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    run_delta(4, 16'd4);
    // Falling edges of the external count input, kept below a quarter rate
    wr(8'hD9, 8'h06);
    snap();
    repeat (3) begin
      @(posedge clk_in) ext_count_input_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      ext_count_input_in <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    run_delta(6, 16'd3);
    // Counter wrap sets both flags; enables gate the request
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h09);
    wr(8'hF9, 8'hF0);
    wr(8'hFA, 8'hFF);
    wr(8'hD8, 8'h40);
    repeat (30) @(posedge clk_in);
    wr(8'hD8, 8'h80);
    rdc(8'hD8, 8'h80);
    chk({15'h0, irq_out}, 16'h0001);
    rdc(8'hF7, 8'h20);
    wr(8'hD9, 8'h08);
    chk({15'h0, irq_out}, 16'h0000);
    wr(8'hF7, 8'h60);
    chk({15'h0, irq_out}, 16'h0001);
    repeat (20) @(posedge clk_in);
    rdc(8'hF7, 8'h60);
    wr(8'hF7, 8'h40);
    rdc(8'hF7, 8'h40);
    chk({15'h0, irq_out}, 16'h0000);
    // Nine-bit cycle: rolling the low byte is not a cycle end, bit nine is
    wr(8'hF7, 8'h01);
    chk({13'h0, cycle_length_sel_out}, 16'h0001);
    wr(8'hF9, 8'hFE);
    wr(8'hFA, 8'h00);
    wr(8'hD8, 8'h40);
    wr(8'hD8, 8'h00);
    rdc(8'hF7, 8'h01);
    wr(8'hFA, 8'h01);
    wr(8'hF9, 8'hFE);
    wr(8'hD8, 8'h40);
    wr(8'hD8, 8'h00);
    rdc(8'hF7, 8'h21);
    // Reload select steers the compare byte addresses
    wr(8'hF7, 8'h00);
    wr(8'hFB, 8'h34);
    wr(8'hFC, 8'h12);
    chk(compare_value_out[15:0], 16'h1234);
    wr(8'hF7, 8'h80);
    wr(8'hFB, 8'h78);
    wr(8'hFC, 8'h56);
    chk(compare_value_out[15:0], 16'h1234);
    rdc(8'hFB, 8'h78);
    wr(8'hF7, 8'h00);
    rdc(8'hFB, 8'h34);
    // Nine-bit cycle end reloads the compare value, except on a 16-bit channel
    channel_pwm16_in <= 3'h1;
    wr(8'hF7, 8'h01);
    wr(8'hFA, 8'h03);
    wr(8'hF9, 8'hFE);
    wr(8'hD8, 8'h40);
    wr(8'hD8, 8'h00);
    chk(compare_value_out[15:0], 16'h1234);
    @(posedge clk_in) channel_pwm16_in <= 3'h0;
    wr(8'hFA, 8'h05);
    wr(8'hF9, 8'hFE);
    wr(8'hD8, 8'h40);
    wr(8'hD8, 8'h00);
    chk(compare_value_out[15:0], 16'h5678);
    // Comparator clear: falling edge on channel zero, then rising edge on channel one
    wr(8'h9C, 8'h01);
    repeat (4) @(negedge clk_in);
    chk({13'h0, channel_output_out}, 16'h0007);
    @(posedge clk_in) comparator_in <= 1'b0;
    repeat (5) @(negedge clk_in);
    chk({13'h0, channel_output_out}, 16'h0006);
    wr(8'h9C, 8'h83);
    @(posedge clk_in) comparator_in <= 1'b1;
    repeat (5) @(negedge clk_in);
    chk({13'h0, channel_output_out}, 16'h0004);
    // Reset in mid-run returns outputs and registers to zero
    @(posedge clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    chk({13'h0, channel_output_out}, 16'h0000);
    chk(main_counter_out, 16'h0000);
    rdc(8'h9C, 8'h00);
    chk({15'h0, irq_out}, 16'h0000);
    report_and_stop();
  end
endmodule // testbench
